// ---- logic/op_status_pkg.sv ----
/*
 * Constants for the flash operation status register: bit positions,
 * command codes and reset values.
 * Assumes one 20 MHz clock domain and a synchronous command stream.
 */
package op_status_pkg;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
	localparam logic [7:0] CMD_RESUME       = 8'hd0;

	localparam int BIT_CTRL_READY    = 7;
	localparam int BIT_ERASE_SUSP    = 6;
	localparam int BIT_ERASE_ERR     = 5;
	localparam int BIT_PROG_ERR      = 4;
	localparam int BIT_SUPPLY_ERR    = 3;
	localparam int BIT_PROG_SUSP     = 2;
	localparam int BIT_PROTECT_ERR   = 1;
	localparam int BIT_UNLOCKED      = 0;

	localparam logic [7:0] STATUS_RESET = 8'h80;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_PROG   = 4'b0010,
		ST_ERASE  = 4'b0100,
		ST_PAUSED = 4'b1000
	} ctrl_state_t;
endpackage : op_status_pkg

// ---- logic/op_status.sv ----
/*
 * Status register of the program/erase controller of a flash memory.
 * Assumes the command decoder presents one-cycle command strobes and
 * the array engine reports verify results and pause points as pulses.
 */
`timescale 1ns/10ps
module op_status
	import op_status_pkg::*;
#(
	parameter bit HAS_PASSWORD = 1'b1
) (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [7:0] cmd_code_i,
	input  wire logic       prog_start_i,
	input  wire logic       erase_start_i,
	input  wire logic       target_protected_i,
	input  wire logic       supply_ok_i,
	input  wire logic       op_done_i,
	input  wire logic       verify_fail_i,
	input  wire logic       unlock_try_i,
	input  wire logic       unlock_ok_i,
	input  wire logic       pause_point_i,
	output logic            array_go_o,
	output logic            ctrl_busy_o,
	output logic [7:0]      low_data_lines_o
);

	// Whole controller state in one register; the status byte is a view of it
	typedef struct packed {
		ctrl_state_t st;
		logic        erase_susp;
		logic        erase_err;
		logic        prog_err;
		logic        supply_err;
		logic        prog_susp;
		logic        protect_err;
		logic        unlocked;
		logic        susp_req;
	} state_t;

	state_t q, d;

	logic clear_cmd, susp_cmd, resume_cmd, start, abort;
	assign clear_cmd  = cmd_valid_i && cmd_code_i == CMD_CLEAR_STATUS;
	assign susp_cmd   = cmd_valid_i && cmd_code_i == CMD_SUSPEND;
	assign resume_cmd = cmd_valid_i && cmd_code_i == CMD_RESUME;
	assign start      = (prog_start_i || erase_start_i) && q.st == ST_IDLE;
	// Supply is looked at only in this start cycle
	assign abort      = start && (target_protected_i || !supply_ok_i);

	always_comb begin
		d = q;
		// Clear first so that a same-cycle event below wins over it
		if (clear_cmd) begin
			d.prog_err    = 1'b0;
			d.supply_err  = 1'b0;
			d.protect_err = 1'b0;
			d.erase_err   = 1'b0;
		end
		if (abort && target_protected_i)
			d.protect_err = 1'b1;
		if (abort && !supply_ok_i)
			d.supply_err = 1'b1;
		// A wrong password reports through the program error bit; an unlock
		// holds until reset, as this block has no relock command
		if (unlock_try_i && q.st == ST_IDLE) begin
			if (unlock_ok_i)
				d.unlocked = 1'b1;
			else
				d.prog_err = 1'b1;
		end
		case (q.st)
			ST_IDLE: begin
				if (start && !abort)
					d.st = prog_start_i ? ST_PROG : ST_ERASE;
			end
			ST_PROG, ST_ERASE: begin
				// Request is held until the engine offers a pause point or ends
				if (susp_cmd)
					d.susp_req = 1'b1;
				// Done wins over a pause point in the same cycle: nothing is left to resume
				if (op_done_i) begin
					d.st = ST_IDLE;
					d.susp_req = 1'b0;
					if (verify_fail_i && q.st == ST_PROG)
						d.prog_err = 1'b1;
					if (verify_fail_i && q.st == ST_ERASE)
						d.erase_err = 1'b1;
				end else if ((q.susp_req || susp_cmd) && pause_point_i) begin
					d.st = ST_PAUSED;
					d.susp_req = 1'b0;
					d.prog_susp  = q.st == ST_PROG;
					d.erase_susp = q.st == ST_ERASE;
				end
			end
			ST_PAUSED: begin
				if (resume_cmd) begin
					d.st = q.prog_susp ? ST_PROG : ST_ERASE;
					d.prog_susp = 1'b0;
					d.erase_susp = 1'b0;
				end
			end
			default: d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{st: ST_IDLE, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Ready comes from the state itself, so it cannot disagree with the array enable
	assign array_go_o  = q.st == ST_PROG || q.st == ST_ERASE;
	assign ctrl_busy_o = array_go_o;

	always_comb begin
		low_data_lines_o = {~array_go_o, q.erase_susp, q.erase_err, q.prog_err,
			q.supply_err, q.prog_susp, q.protect_err,
			HAS_PASSWORD ? q.unlocked : 1'b1};
	end

	// Sticky error bits: set by their event, dropped only by clear status or reset
	AST_PROT_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
		start && target_protected_i |=> q.protect_err && q.st == ST_IDLE)
		else $error("protect bit not set or not idle");
	AST_SUPPLY_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
		start && !supply_ok_i |=> q.supply_err && q.st == ST_IDLE)
		else $error("supply bit not set or not idle");
	AST_STICKY: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.prog_err && !clear_cmd |=> q.prog_err)
		else $error("program error bit dropped");
	AST_STICKY_SUPPLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.supply_err && !clear_cmd |=> q.supply_err)
		else $error("supply error bit dropped");
	AST_STICKY_PROTECT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.protect_err && !clear_cmd |=> q.protect_err)
		else $error("protect error bit dropped");
	AST_STICKY_ERASE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.erase_err && !clear_cmd |=> q.erase_err)
		else $error("erase error bit dropped");
	AST_CLEAR_ERRORS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clear_cmd && q.st == ST_IDLE && !start && !unlock_try_i
		|=> !q.prog_err && !q.supply_err && !q.protect_err && !q.erase_err)
		else $error("clear status left an error bit set");
	AST_PROG_FAIL: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PROG && op_done_i && verify_fail_i |=> q.prog_err)
		else $error("program failure not flagged");
	AST_ERASE_FAIL: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_ERASE && op_done_i && verify_fail_i |=> q.erase_err)
		else $error("erase failure not flagged");

	// Supply is judged once per start; a refused start never enables the array
	AST_SUPPLY_IGNORED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st != ST_IDLE && !q.supply_err |=> !q.supply_err)
		else $error("supply bit set while an operation ran");
	AST_ABORT_NO_GO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		abort |=> !array_go_o && low_data_lines_o[BIT_CTRL_READY])
		else $error("refused operation reached the array");

	// Suspend and resume
	AST_RESUME: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PAUSED && resume_cmd |=> !q.prog_susp && !q.erase_susp)
		else $error("suspend bit kept after resume");
	AST_BUSY_UNTIL_PAUSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PROG && susp_cmd && !pause_point_i && !op_done_i
		|=> !low_data_lines_o[BIT_CTRL_READY])
		else $error("ready before pause");
	AST_SUSP_READY: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.prog_susp |-> low_data_lines_o[BIT_CTRL_READY])
		else $error("suspended but busy");
	AST_PROG_SUSP_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PROG && (q.susp_req || susp_cmd) && pause_point_i && !op_done_i
		|=> q.prog_susp && low_data_lines_o[BIT_CTRL_READY])
		else $error("program pause not reported");
	AST_ERASE_SUSP_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_ERASE && (q.susp_req || susp_cmd) && pause_point_i && !op_done_i
		|=> q.erase_susp && low_data_lines_o[BIT_CTRL_READY])
		else $error("erase pause not reported");
	AST_DONE_NO_SUSP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PROG && op_done_i |=> q.st == ST_IDLE && !q.prog_susp)
		else $error("suspend bit set after completion");

	// Lock state
	AST_CLEAR_KEEPS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		clear_cmd && q.st == ST_IDLE && !unlock_try_i |=> $stable(q.unlocked))
		else $error("clear altered lock state");
	AST_RESET_LOCK: assert property (@(posedge clk_i)
		$rose(rstn_i) |-> low_data_lines_o[BIT_UNLOCKED] == !HAS_PASSWORD)
		else $error("not locked after reset");

	COV_PROG_DONE: cover property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PROG ##1 q.st == ST_IDLE);
	COV_SUSPEND: cover property (@(posedge clk_i) disable iff (!rstn_i)
		q.st == ST_PAUSED ##[1:20] resume_cmd);
	COV_ABORT: cover property (@(posedge clk_i) disable iff (!rstn_i) abort);
	COV_UNLOCK: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(q.unlocked));

endmodule : op_status

// ---- bench/engine_model.sv ----
/* Array engine model: ends or pauses a running operation; assumes go_i is the run level. */
`timescale 1ns/10ps
module engine_model (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic go_i,
	input  wire logic fail_i,
	input  wire logic pause_req_i,
	output logic      op_done_o,
	output logic      verify_fail_o,
	output logic      pause_point_o
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i) cnt_q <= 4'h0;
		else cnt_q <= go_i ? cnt_q + 4'h1 : 4'h0;
	assign op_done_o     = go_i && cnt_q == 4'h5 && !pause_req_i;
	assign pause_point_o = go_i && cnt_q == 4'h3 && pause_req_i;
	assign verify_fail_o = op_done_o ? fail_i : ~fail_i; // Garbage outside done
endmodule : engine_model

// ---- bench/tb_op_status.sv ----
/* Bench for op_status; assumes the engine model answers every started operation. */
`timescale 1ns/10ps
module tb_op_status;
	import op_status_pkg::*;
	logic       clk_i = 0, rstn_i = 0, cv = 0, pg = 0, er = 0, ut = 0, pr = 0, ok = 1;
	logic       uk = 0, fl = 0, rq = 0, dn, vf, pp, go, bz;
	logic [7:0] cc = 8'h00, st, st_np;
	int         n_fail = 0, n_compared = 0;
	always #25 clk_i = ~clk_i;
	op_status uut (.clk_i, .rstn_i, .cmd_valid_i(cv), .cmd_code_i(cc), .prog_start_i(pg),
		.erase_start_i(er), .target_protected_i(pr), .supply_ok_i(ok), .op_done_i(dn),
		.verify_fail_i(vf), .unlock_try_i(ut), .unlock_ok_i(uk), .pause_point_i(pp),
		.array_go_o(go), .ctrl_busy_o(bz), .low_data_lines_o(st));
	engine_model eng (.clk_i, .rstn_i, .go_i(go), .fail_i(fl), .pause_req_i(rq),
		.op_done_o(dn), .verify_fail_o(vf), .pause_point_o(pp));
	// Variant without password; same stimulus, so it tracks uut except in bit 0
	op_status #(.HAS_PASSWORD(1'b0)) uut_np (.clk_i, .rstn_i, .cmd_valid_i(cv),
		.cmd_code_i(cc), .prog_start_i(pg), .erase_start_i(er), .target_protected_i(pr),
		.supply_ok_i(ok), .op_done_i(dn), .verify_fail_i(vf), .unlock_try_i(ut),
		.unlock_ok_i(uk), .pause_point_i(pp), .array_go_o(), .ctrl_busy_o(),
		.low_data_lines_o(st_np));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("%0d compared, %0d wrong", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic hit(input logic [3:0] p, input logic [2:0] l, input logic [7:0] c);
		{pr, ok, uk} = l;
		{cv, pg, er, ut, cc} = {p, c};
		@(posedge clk_i) #1;
		{cv, pg, er, ut} = 4'h0;
		@(posedge clk_i) #1; // Lets the status land before checks
	endtask : hit
	task automatic idle(input logic [7:0] exp);
		int i;
		for (i = 0; i < 40 && (st[7] !== 1'b1 || go !== 1'b0); i++)
			@(posedge clk_i) #1;
		if (i == 40) begin
			n_fail++;
			$display("wait for ready ran out at %0t", $time);
			end_sim;
		end else begin
			chk(st, exp);
		end
	endtask : idle
	initial begin
		repeat (3) @(posedge clk_i);
		#1 rstn_i = 1;
		chk(st, STATUS_RESET);
		chk(st_np, 8'h81);
		fl = 1;
		hit(4'h4, 3'b010, 8'h00);
		chk({st[7], 5'h00, go, bz}, 8'h03);
		idle(8'h90);
		chk(st_np, 8'h91);
		hit(4'h8, 3'b010, CMD_CLEAR_STATUS);
		chk(st, 8'h80);
		hit(4'h4, 3'b000, 8'h00);
		chk(st, 8'h88);
		chk({7'h00, go}, 8'h00);
		hit(4'h2, 3'b110, 8'h00);
		chk(st, 8'h8a);
		hit(4'h8, 3'b010, CMD_CLEAR_STATUS);
		hit(4'h2, 3'b010, 8'h00);
		idle(8'ha0);
		hit(4'h8, 3'b010, CMD_CLEAR_STATUS);
		for (int e = 0; e < 2; e++) begin
			{rq, fl} = 2'b10;
			hit(e ? 4'h2 : 4'h4, 3'b010, 8'h00);
			hit(4'h8, 3'b000, CMD_SUSPEND);
			idle(e ? 8'hc0 : 8'h84);
			rq = 0;
			hit(4'h8, 3'b010, CMD_RESUME);
			chk(st, 8'h00);
			idle(8'h80);
		end
		hit(4'h1, 3'b010, 8'h00);
		chk(st, 8'h90);
		hit(4'h1, 3'b011, 8'h00);
		hit(4'h8, 3'b010, CMD_CLEAR_STATUS);
		chk(st, 8'h81);
		chk(st_np, 8'h81);
		rstn_i = 0;
		#1 chk(st, 8'h80);
		@(posedge clk_i) #1 rstn_i = 1;
		@(posedge clk_i) #1 chk(st, STATUS_RESET);
		chk(st_np, 8'h81);
		end_sim;
	end
endmodule : tb_op_status
